// file: fsrw_slave_window.sv
// fieldbus slave register window: addressed register read/preset engine
//
// How it works
// R1 - responder only, answers requests to itself
// R2 - only addressed commands, broadcast never serviced
// R3 - code 3 reads instrument data 40001-40161
// R4 - instrument-to-bus area never written from bus
// R5 - codes 16 and 6 store 41025-41185
// R6 - bus-to-instrument area readable by code 3
// R7 - address is 64 minus inverted switch value
// R8 - origin switch bank has no effect
// R9 - data image sized for 322 bytes (161 words) per area
// R10 - activity lamp: normal blink, listen-only 1 s
// R11 - never-token idle: two flashes, 2 s off
// R12 - no other nodes: three flashes, 1.7 s
// R13 - duplicate address: four flashes, 1.4 s
// R14 - init lamp dark until initialised, then green
// R15 - each register number is one word
// R16 - bad code or address gets exception
// R17 - error lamp red on communication failure
`timescale 1ns/10ps
`include "fsrw_regs.svh"
module fsrw_slave_window
  import fsrw_pkg::*;
#(
  parameter int AREA_WORDS = `FSRW_AREA_WORDS, // [R9] words per area
  parameter int TICK_CYCLES = `FSRW_TICK_CYCLES // clock cycles per flash tick
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // switches
  input wire logic [5:0] stationAddrSw,
  input wire logic [7:0] unusedOriginSwitchBank,
  output logic [6:0] stationAddress,
  // parsed request from the link layer
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [7:0] reqDest,
  input wire logic [7:0] reqFunc,
  input wire logic [15:0] reqStart,
  input wire logic [7:0] reqCount,
  // preset data words
  input wire logic wordValid,
  output logic wordReady,
  input wire logic [15:0] wordData,
  // response to the link layer
  output logic rspValid,
  input wire logic rspReady,
  output logic [15:0] rspWord,
  output logic rspLast,
  output logic rspExcept,
  output logic [7:0] rspCode,
  // instrument side of the data image
  input wire logic instWrEn,
  input wire logic [7:0] instWrIdx,
  input wire logic [15:0] instWrData,
  input wire logic [7:0] instRdIdx,
  output logic [15:0] instRdData,
  // link status
  input wire fsrw_pkg::fsrw_health_type netHealth,
  input wire logic ifaceInitDone,
  input wire logic commFail,
  // indicators
  output logic networkActivityIndicator,
  output logic interfaceInitIndicator,
  output logic errorIndicator
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (AREA_WORDS < 1 || AREA_WORDS > 255)
      $error("AREA_WORDS must fit an 8-bit index");
    if (TICK_CYCLES < 2)
      $error("TICK_CYCLES must be at least 2");
  endgenerate

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [16:0] AREA_END = 17'(AREA_WORDS);

  fsrw_state_type state_r; // request engine state
  logic [6:0] stationAddr_r; // decoded node address
  logic [15:0] inMem [AREA_WORDS]; // instrument-to-bus area
  logic [15:0] outMem [AREA_WORDS]; // bus-to-instrument area
  logic [7:0] ptr_r; // current word index
  logic [7:0] left_r; // words still to move
  logic [7:0] count_r; // word count echoed in the write answer
  logic areaOut_r; // read serves the bus-to-instrument area
  logic excPend_r; // answer pending is an exception
  logic [7:0] excCode_r; // exception code pending
  logic rspValid_r; // response word held
  logic [15:0] rspWord_r; // response data
  logic rspLast_r; // last word of the response
  logic rspExcept_r; // response is an exception
  logic [7:0] rspCode_r; // exception code out
  logic [15:0] instRdData_r; // instrument read data
  logic [TW-1:0] tickCnt_r; // flash timebase divider
  logic tick; // one-cycle flash tick

  // decode helpers
  logic take; // request accepted this cycle
  logic forMe; // request addressed to this node
  logic isRead; // read holding registers
  logic isWrite; // single or multiple preset
  logic [7:0] effCount; // words named by the request
  logic [16:0] inOff; // offset into instrument-to-bus area
  logic [16:0] outOff; // offset into bus-to-instrument area
  logic inHit; // request fits the instrument-to-bus area
  logic outHit; // request fits the bus-to-instrument area
  logic rspLoad; // response register may take a new word
  logic wordTake; // preset word accepted this cycle

  // the origin bank is wired in only so the pins exist; nothing reads it [R8]

  // ----------------------------------------------------------------
  // station address: switch on = 1, value is 64 minus address
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      stationAddr_r <= `FSRW_ADDR_TOP;
    else
      stationAddr_r <= 7'(`FSRW_ADDR_TOP - {1'b0, stationAddrSw}); // [R7]
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  always_comb
  begin
    isRead = (reqFunc == `FSRW_FC_READ_HOLD);
    isWrite = (reqFunc == `FSRW_FC_PRESET_ONE) || (reqFunc == `FSRW_FC_PRESET_MANY);
    // a single preset always moves exactly one word, whatever the count field says
    effCount = (reqFunc == `FSRW_FC_PRESET_ONE) ? 8'h01 : reqCount;
    // one register number per word, first number is word zero [R15]
    inOff = {1'b0, reqStart} - {1'b0, `FSRW_IN_BASE};
    outOff = {1'b0, reqStart} - {1'b0, `FSRW_OUT_BASE};
    // borrow bit set means below the area base
    inHit = !inOff[16] && (effCount != 8'h00) && (17'(inOff + {9'h000, effCount}) <= AREA_END);
    outHit = !outOff[16] && (effCount != 8'h00) && (17'(outOff + {9'h000, effCount}) <= AREA_END);
    // broadcast address 0 never matches a station of 1..64 [R2]
    forMe = (reqDest == {1'b0, stationAddr_r}); // [R1]
  end

  // accept only when idle and the previous answer has left
  assign reqReady = (state_r == ST_IDLE) && !rspValid_r;
  assign take = reqValid && reqReady;
  assign wordReady = (state_r == ST_WRITE);
  assign wordTake = wordValid && wordReady;
  assign rspLoad = !rspValid_r || rspReady;

  // ----------------------------------------------------------------
  // request engine: never starts traffic, only follows accepted requests
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      ptr_r <= 8'h00;
      left_r <= 8'h00;
      count_r <= 8'h00;
      areaOut_r <= 1'b0;
      excPend_r <= 1'b0;
      excCode_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          // requests for other nodes are dropped without an answer [R1]
          if (take && forMe)
          begin
            count_r <= effCount;
            left_r <= effCount;
            excPend_r <= 1'b0;
            if (!isRead && !isWrite)
            begin
              excPend_r <= 1'b1; // [R16] illegal function
              excCode_r <= `FSRW_EXC_BAD_FUNC;
              state_r <= ST_RESP;
            end
            else if (isRead && (inHit || outHit))
            begin
              areaOut_r <= !inHit; // [R3] [R6]
              ptr_r <= inHit ? inOff[7:0] : outOff[7:0];
              state_r <= ST_READ;
            end
            else if (isWrite && outHit)
            begin
              ptr_r <= outOff[7:0]; // [R5]
              state_r <= ST_WRITE;
            end
            else
            begin
              // covers presets aimed at the read-only area as well [R4] [R16]
              excPend_r <= 1'b1;
              excCode_r <= `FSRW_EXC_BAD_ADDR;
              state_r <= ST_RESP;
            end
          end
        end
        ST_READ:
        begin
          if (rspLoad)
          begin
            ptr_r <= 8'(ptr_r + 8'h01);
            left_r <= 8'(left_r - 8'h01);
            if (left_r == 8'h01)
              state_r <= ST_IDLE;
          end
        end
        ST_WRITE:
        begin
          if (wordTake)
          begin
            ptr_r <= 8'(ptr_r + 8'h01);
            left_r <= 8'(left_r - 8'h01);
            if (left_r == 8'h01)
              state_r <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          if (rspLoad)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // response register: data words, write echo or exception
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rspValid_r <= 1'b0;
      rspWord_r <= 16'h0000;
      rspLast_r <= 1'b0;
      rspExcept_r <= 1'b0;
      rspCode_r <= 8'h00;
    end
    else if (state_r == ST_READ && rspLoad)
    begin
      rspValid_r <= 1'b1;
      rspWord_r <= areaOut_r ? outMem[ptr_r] : inMem[ptr_r]; // [R6] [R15]
      rspLast_r <= (left_r == 8'h01);
      rspExcept_r <= 1'b0;
      rspCode_r <= 8'h00;
    end
    else if (state_r == ST_RESP && rspLoad)
    begin
      rspValid_r <= 1'b1;
      rspWord_r <= {8'h00, count_r};
      rspLast_r <= 1'b1;
      rspExcept_r <= excPend_r; // [R16]
      rspCode_r <= excPend_r ? excCode_r : 8'h00;
    end
    else if (rspValid_r && rspReady)
      rspValid_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // data image; only the instrument port writes the instrument area
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // cleared so an early read never returns junk; costs a wide reset fan-out
      for (int i = 0; i < AREA_WORDS; i++)
      begin
        inMem[i] <= 16'h0000;
        outMem[i] <= 16'h0000;
      end
      instRdData_r <= 16'h0000;
    end
    else
    begin
      if (instWrEn && (instWrIdx < 8'(AREA_WORDS)))
        inMem[instWrIdx] <= instWrData; // [R4]
      if (wordTake)
        outMem[ptr_r] <= wordData; // [R5]
      instRdData_r <= (instRdIdx < 8'(AREA_WORDS)) ? outMem[instRdIdx] : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // flash timebase divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tickCnt_r <= '0;
    else if (tick)
      tickCnt_r <= '0;
    else
      tickCnt_r <= TW'(tickCnt_r + 1'b1);
  end
  assign tick = (tickCnt_r == TW'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // indicator driver
  // ----------------------------------------------------------------
  fsrw_led_if ledBus ();
  assign ledBus.tick = tick;
  assign ledBus.initDone = ifaceInitDone;
  assign ledBus.commFail = commFail;
  assign ledBus.health = netHealth;

  fsrw_led_pattern ledDrv (
    .clk (clk),
    .rst_n (rst_n),
    .leds (ledBus.drv)
  );

  assign networkActivityIndicator = ledBus.ledActivity;
  assign interfaceInitIndicator = ledBus.ledInit;
  assign errorIndicator = ledBus.ledError;
  assign stationAddress = stationAddr_r;
  assign rspValid = rspValid_r;
  assign rspWord = rspWord_r;
  assign rspLast = rspLast_r;
  assign rspExcept = rspExcept_r;
  assign rspCode = rspCode_r;
  assign instRdData = instRdData_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_addr_range: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    ##1 (stationAddress == 7'(7'h40 - {1'b0, $past(stationAddrSw)})) && (stationAddress != 7'h00))
    else $error("station address not 64 minus switch value");
  chk_foreign_drop: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    take && !forMe |=> state_r == ST_IDLE ##1 !rspValid)
    else $error("answered a request for another node");
  chk_bad_function: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    take && forMe && !isRead && !isWrite |=> ##1 rspValid && rspExcept && rspCode == 8'h01)
    else $error("bad function not answered with exception 1");
  chk_ro_protect: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    take && forMe && isWrite && !outHit |=> !wordReady ##1 rspExcept && rspCode == 8'h02)
    else $error("preset outside writable area not refused");
  chk_read_start: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    take && forMe && isRead && inHit |=> ##1 rspValid && !rspExcept)
    else $error("read of instrument area gave no data");
  chk_preset_store: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    wordTake |=> outMem[$past(ptr_r)] == $past(wordData))
    else $error("preset word not stored");
  chk_hold_answer: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
    rspValid && !rspReady |=> rspValid && $stable(rspWord) && $stable(rspLast))
    else $error("response changed while stalled");
  chk_single_preset: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    take && forMe && reqFunc == 8'h06 && outHit |=> wordReady && left_r == 8'h01)
    else $error("single preset did not expect one word");

endmodule : fsrw_slave_window

// file: fsrw_regs.svh
// constants of the fieldbus slave register window: codes, areas and timing
`ifndef FSRW_REGS_SVH
`define FSRW_REGS_SVH

// ----------------------------------------------------------------
// function codes and exception codes
// ----------------------------------------------------------------
`define FSRW_FC_READ_HOLD 8'h03
`define FSRW_FC_PRESET_ONE 8'h06
`define FSRW_FC_PRESET_MANY 8'h10
`define FSRW_EXC_BAD_FUNC 8'h01
`define FSRW_EXC_BAD_ADDR 8'h02

// ----------------------------------------------------------------
// register number areas (first number selects word zero)
// ----------------------------------------------------------------
`define FSRW_IN_BASE 16'h9c41
`define FSRW_OUT_BASE 16'ha041
`define FSRW_AREA_WORDS 161
`define FSRW_ADDR_TOP 7'h40

// ----------------------------------------------------------------
// timing: clock rate, flash tick and indicator periods
// ----------------------------------------------------------------
`define FSRW_CLK_KHZ 40000
`define FSRW_TICK_MS 100
`define FSRW_TICK_CYCLES (`FSRW_CLK_KHZ * `FSRW_TICK_MS)
`define FSRW_LISTEN_PERIOD_MS 1000
`define FSRW_IDLE_OFF_MS 2000
`define FSRW_QUIET_OFF_MS 1700
`define FSRW_DUP_OFF_MS 1400

`endif

// file: fsrw_pkg.sv
// types shared by the fieldbus slave register window modules
package fsrw_pkg;

  // ----------------------------------------------------------------
  // request engine states, gray along idle-read / write-resp-idle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11,
    ST_RESP  = 2'b10
  } fsrw_state_type;

  // ----------------------------------------------------------------
  // node health reported by the token layer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HL_TOKEN_OK    = 3'h0,
    HL_LISTEN_ONLY = 3'h1,
    HL_NEVER_TOKEN = 3'h2,
    HL_NO_OTHERS   = 3'h3,
    HL_DUP_ADDR    = 3'h4
  } fsrw_health_type;

endpackage : fsrw_pkg

// file: fsrw_led_if.sv
// carrier between the window top level (flash tick and link status inputs) and the indicator driver
`timescale 1ns/10ps
interface fsrw_led_if;
  logic tick; // one-cycle flash timebase enable
  logic initDone; // interface initialised
  logic commFail; // communication failure seen
  fsrw_pkg::fsrw_health_type health; // node health
  logic ledActivity; // network activity indicator
  logic ledInit; // interface init indicator
  logic ledError; // error indicator

  modport ctrl (output tick, output initDone, output commFail, output health,
                input ledActivity, input ledInit, input ledError);
  modport drv (input tick, input initDone, input commFail, input health,
               output ledActivity, output ledInit, output ledError);
endinterface : fsrw_led_if

// file: fsrw_led_pattern.sv
// indicator driver: flash patterns for node health, init and error lamps
`timescale 1ns/10ps
`include "fsrw_regs.svh"
module fsrw_led_pattern
  import fsrw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // indicator carrier
  fsrw_led_if.drv leds
);

  // ----------------------------------------------------------------
  // pattern lengths in flash ticks
  // ----------------------------------------------------------------
  localparam int LISTEN_OFF = `FSRW_LISTEN_PERIOD_MS / `FSRW_TICK_MS - 1; // one tick lit
  localparam int IDLE_OFF = `FSRW_IDLE_OFF_MS / `FSRW_TICK_MS;
  localparam int QUIET_OFF = `FSRW_QUIET_OFF_MS / `FSRW_TICK_MS;
  localparam int DUP_OFF = `FSRW_DUP_OFF_MS / `FSRW_TICK_MS;

  logic [5:0] flashes; // flashes in one burst
  logic [5:0] offTicks; // dark ticks closing the burst
  logic [5:0] step_r; // position inside the burst
  logic [5:0] seqLast; // last step of the burst
  fsrw_health_type healthPrev_r; // health seen last cycle
  logic ledActivity_r; // activity lamp
  logic ledInit_r; // init lamp
  logic ledError_r; // error lamp

  // ----------------------------------------------------------------
  // health to pattern table
  // ----------------------------------------------------------------
  always_comb
  begin
    case (leds.health)
      HL_TOKEN_OK: begin flashes = 6'h01; offTicks = 6'h01; end // [R10] steady blink
      HL_LISTEN_ONLY: begin flashes = 6'h01; offTicks = 6'(LISTEN_OFF); end // [R10]
      HL_NEVER_TOKEN: begin flashes = 6'h02; offTicks = 6'(IDLE_OFF); end // [R11]
      HL_NO_OTHERS: begin flashes = 6'h03; offTicks = 6'(QUIET_OFF); end // [R12]
      HL_DUP_ADDR: begin flashes = 6'h04; offTicks = 6'(DUP_OFF); end // [R13]
      default: begin flashes = 6'h01; offTicks = 6'h01; end
    endcase
    // burst = lit/dark pairs, the last dark gap replaced by the long pause
    seqLast = 6'((flashes << 1) - 6'h02 + offTicks);
  end

  // ----------------------------------------------------------------
  // burst stepping; a health change restarts the burst so patterns never blend
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_r <= 6'h00;
      healthPrev_r <= HL_TOKEN_OK;
    end
    else
    begin
      healthPrev_r <= leds.health;
      if (leds.health != healthPrev_r)
        step_r <= 6'h00;
      else if (leds.tick)
        step_r <= (step_r >= seqLast) ? 6'h00 : 6'(step_r + 6'h01);
    end
  end

  // ----------------------------------------------------------------
  // lamps, all registered; activity stays dark until init completes
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ledActivity_r <= 1'b0;
      ledInit_r <= 1'b0;
      ledError_r <= 1'b0;
    end
    else
    begin
      ledActivity_r <= leds.initDone && !step_r[0] && (step_r < 6'((flashes << 1) - 6'h01)); // [R10]
      ledInit_r <= leds.initDone; // [R14]
      ledError_r <= leds.commFail; // [R17]
    end
  end

  assign leds.ledActivity = ledActivity_r;
  assign leds.ledInit = ledInit_r;
  assign leds.ledError = ledError_r;

  chk_init_lamp: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    !leds.initDone ##1 !leds.initDone |-> !leds.ledInit)
    else $error("init lamp lit before initialisation");
  chk_error_lamp: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
    leds.commFail |=> leds.ledError)
    else $error("error lamp dark on failure");

endmodule : fsrw_led_pattern

// file: fsrw_master_model.sv
// remote fieldbus master model issuing addressed register commands
`timescale 1ns/10ps
module fsrw_master_model
(
  // clock
  input wire logic clk,
  // request channel
  output logic reqValid,
  input wire logic reqReady,
  output logic [7:0] reqDest,
  output logic [7:0] reqFunc,
  output logic [15:0] reqStart,
  output logic [7:0] reqCount,
  // preset word channel
  output logic wordValid,
  input wire logic wordReady,
  output logic [15:0] wordData,
  // answer channel and hang flag
  output logic rspReady,
  output logic hang
);
  // ----------------------------------------------------------------
  // idle lines, answer stalls and noise on released lines
  // ----------------------------------------------------------------
  initial
  begin
    {reqValid, wordValid, rspReady, hang} = 4'h0;
    {reqDest, reqFunc, reqStart, reqCount, wordData} = '0;
  end
  // noise lands a delta after the bench so a fresh request wins the step
  always @(posedge clk)
  begin
    #1 rspReady = ($urandom_range(3) != 0);
    #0 if (!reqValid) {reqDest, reqFunc, reqStart, reqCount} = 40'({$urandom, $urandom});
    if (!wordValid) wordData = 16'($urandom);
  end
  // one request, addressed or broadcast, held until taken
  task automatic req(input logic [7:0] d, f, input logic [15:0] s, input logic [7:0] n);
    int i;
    {reqDest, reqFunc, reqStart, reqCount} = {d, f, s, n};
    reqValid = 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (reqReady === 1'b1) break;
    end
    hang = (i == 50);
    #1 reqValid = 1'b0;
  endtask : req
  // one preset word; valid stays up so words can follow back to back
  task automatic word(input logic [15:0] w);
    int i;
    wordData = w;
    wordValid = 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (wordReady === 1'b1) break;
    end
    hang = (i == 50);
    #1;
  endtask : word
  task automatic wordEnd;
    wordValid = 1'b0;
  endtask : wordEnd
endmodule : fsrw_master_model

// file: tb.sv
// self-checking bench for the fieldbus slave register window
`timescale 1ns/10ps
`include "fsrw_regs.svh"
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin failCount++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
  import fsrw_pkg::*;
  localparam int TICK = 4; // short flash tick keeps blink checks brief
  logic clk, rst_n, reqValid, reqReady, wordValid, wordReady, rspValid, rspReady, rspLast, rspExcept;
  logic instWrEn, ifaceInitDone, commFail, hang, netAct, ledInit, ledErr, prev;
  logic [5:0] stationAddrSw;
  logic [6:0] stationAddress;
  logic [7:0] unusedOriginSwitchBank, reqDest, reqFunc, reqCount, rspCode, instWrIdx, instRdIdx, myAddr;
  logic [15:0] reqStart, wordData, rspWord, instWrData, instRdData;
  logic [15:0] img[4]; // data words of the running scenario
  logic [25:0] expQ[$]; // notes: except, last, code, word
  logic [25:0] cur;
  logic [5:0] sw[4] = '{6'h3f, 6'h00, 6'h01, 6'h2a};
  int nb[5] = '{1, 1, 2, 3, 4}; // flashes per burst, by health
  int pz[5] = '{1, 9, 20, 17, 14}; // pause ticks, by health
  int rises, per;
  int failCount = 0;
  int samplesChecked = 0;
  fsrw_health_type netHealth;
  fsrw_slave_window #(.TICK_CYCLES(TICK)) fsrw_slave_window_inst (.clk, .rst_n, .stationAddrSw,
    .unusedOriginSwitchBank, .stationAddress, .reqValid, .reqReady, .reqDest, .reqFunc, .reqStart, .reqCount,
    .wordValid, .wordReady, .wordData, .rspValid, .rspReady, .rspWord, .rspLast, .rspExcept, .rspCode, .instWrEn,
    .instWrIdx, .instWrData, .instRdIdx, .instRdData, .netHealth, .ifaceInitDone, .commFail,
    .networkActivityIndicator(netAct), .interfaceInitIndicator(ledInit), .errorIndicator(ledErr));
  fsrw_master_model fsrw_master_model_inst (.clk, .reqValid, .reqReady, .reqDest, .reqFunc, .reqStart,
    .reqCount, .wordValid, .wordReady, .wordData, .rspReady, .hang);
  // ----------------------------------------------------------------
  // clock, verdict and answer watcher
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic summarize;
    if (failCount == 0 && samplesChecked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  always @(posedge hang)
  begin
    failCount++;
    summarize();
  end
  // every taken answer is matched against the oldest note
  always @(posedge clk)
    if (rst_n === 1'b1 && rspValid === 1'b1 && rspReady === 1'b1)
    begin
      if (expQ.size() == 0) `CHK(rspValid, 1'b0)
      else
      begin
        cur = expQ.pop_front();
        `CHK(rspExcept, cur[25])
        if (cur[25]) `CHK(rspCode, cur[23:16])
        else `CHK({rspLast, rspWord}, {cur[24], cur[15:0]})
      end
    end
  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic note(input logic ex, la, input logic [7:0] c, input logic [15:0] w);
    expQ.push_back({ex, la, c, w});
  endtask : note
  // waits, bounded, until every noted answer has been taken
  task automatic drain;
    for (int i = 0; i < 300 && expQ.size() != 0; i++) @(posedge clk);
    if (expQ.size() != 0)
    begin
      failCount++;
      summarize();
    end
    step(3);
  endtask : drain
  task automatic cmd(input logic [7:0] f, input logic [15:0] s, input logic [7:0] n, input int nw);
    fsrw_master_model_inst.req(myAddr, f, s, n);
    for (int i = 0; i < nw; i++) fsrw_master_model_inst.word(img[i]);
    if (nw > 0) fsrw_master_model_inst.wordEnd();
    drain();
  endtask : cmd
  // read of n words, expected from img starting at k
  task automatic rd(input logic [15:0] s, input logic [7:0] n, input int k);
    for (int i = 0; i < n; i++) note(1'b0, i == n - 1, 8'h00, img[k + i]);
    cmd(`FSRW_FC_READ_HOLD, s, n, 0);
  endtask : rd
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h2a8d324b));
    {rst_n, stationAddrSw, unusedOriginSwitchBank, instWrEn, instWrIdx, instWrData, instRdIdx} = '0;
    {ifaceInitDone, commFail} = 2'b00;
    netHealth = HL_TOKEN_OK;
    step(6);
    `CHK(ledInit, 1'b0)
    rst_n = 1'b1;
    // inverted address switches while the origin bank wanders
    foreach (sw[k])
    begin
      stationAddrSw = sw[k];
      unusedOriginSwitchBank = 8'($urandom);
      step(2);
      `CHK(stationAddress, 7'h40 - {1'b0, sw[k]})
    end
    myAddr = 8'h40 - {2'b00, stationAddrSw};
    foreach (img[i]) img[i] = 16'($urandom);
    instWrEn = 1'b1;
    {instWrIdx, instWrData} = {8'd0, img[0]};
    step(1);
    {instWrIdx, instWrData} = {8'd1, img[1]};
    step(1);
    {instWrIdx, instWrData} = {8'd160, img[2]};
    step(1);
    instWrEn = 1'b0;
    rd(`FSRW_IN_BASE, 8'd2, 0);
    rd(`FSRW_IN_BASE + 16'd160, 8'd1, 2);
    // refusals: preset into the read-only area, bad code, bad numbers
    note(1'b1, 1'b1, `FSRW_EXC_BAD_ADDR, 16'h0000);
    cmd(`FSRW_FC_PRESET_MANY, `FSRW_IN_BASE, 8'd1, 0);
    rd(`FSRW_IN_BASE, 8'd1, 0);
    note(1'b1, 1'b1, `FSRW_EXC_BAD_FUNC, 16'h0000);
    cmd(8'h05, `FSRW_IN_BASE, 8'd1, 0);
    note(1'b1, 1'b1, `FSRW_EXC_BAD_ADDR, 16'h0000);
    cmd(`FSRW_FC_READ_HOLD, `FSRW_IN_BASE + 16'd161, 8'd1, 0);
    // other destinations and broadcast are dropped silently
    fsrw_master_model_inst.req(myAddr + 8'd1, `FSRW_FC_READ_HOLD, `FSRW_IN_BASE, 8'd1);
    step(2);
    fsrw_master_model_inst.req(8'h00, `FSRW_FC_READ_HOLD, `FSRW_IN_BASE, 8'd1);
    step(20);
    // presets to the bus-to-instrument area, back-to-back words
    foreach (img[i]) img[i] = 16'($urandom);
    note(1'b0, 1'b1, 8'h00, 16'h0003);
    cmd(`FSRW_FC_PRESET_MANY, `FSRW_OUT_BASE, 8'd3, 3);
    for (int i = 0; i < 3; i++)
    begin
      instRdIdx = 8'(i);
      step(2);
      `CHK(instRdData, img[i])
    end
    rd(`FSRW_OUT_BASE, 8'd3, 0);
    note(1'b0, 1'b1, 8'h00, 16'h0001);
    cmd(`FSRW_FC_PRESET_ONE, `FSRW_OUT_BASE + 16'd160, 8'd5, 1);
    instRdIdx = 8'd160;
    step(2);
    `CHK(instRdData, img[0])
    rd(`FSRW_OUT_BASE + 16'd160, 8'd1, 0);
    // lamps: init, error and health blink patterns
    {ifaceInitDone, commFail} = 2'b11;
    step(2);
    `CHK({ledInit, ledErr}, 2'b11)
    commFail = 1'b0;
    step(2);
    `CHK(ledErr, 1'b0)
    foreach (nb[h])
    begin
      netHealth = fsrw_health_type'(h);
      per = 2 * nb[h] - 1 + pz[h];
      {rises, prev} = '0;
      for (int c = 0; c < 10 * per * TICK; c++)
      begin
        @(posedge clk);
        rises += int'(netAct === 1'b1 && prev !== 1'b1);
        prev = netAct;
      end
      #1;
      `CHK(rises inside {[9 * nb[h] : 11 * nb[h]]}, 1'b1)
    end
    summarize();
  end
endmodule : tb
